// ==== rtl/fdh_params.svh ====
// constants for the fixed disk host attachment
// Summary of operation
// - four-bit select picks the internal register
// - one bidirectional active-high byte bus
// - read strobe drives addressed register out
// - write strobe captures bus into register
// - hold reset while drive reset, then initialise
// - interrupt after status return, when enabled
// - ready low inserts wait states
// - dma request held until acknowledge, enabled
// - presence output held asserted
`ifndef FDH_PARAMS_SVH
`define FDH_PARAMS_SVH
`define FDH_REG_DATA 4'h0
`define FDH_REG_STATUS 4'h1
`define FDH_REG_CMD 4'h2
`define FDH_REG_CTRL 4'h3
`define FDH_CTRL_IRQ_EN 0
`define FDH_CTRL_DMA_EN 1
`define FDH_CTRL_RESET 8'h00
`define FDH_ST_BUSY 0
`define FDH_ST_IRQ 1
`define FDH_ST_DREQ 2
`define FDH_INIT_NS 40
`define FDH_CLK_NS 4
`define FDH_INIT_CYC ((`FDH_INIT_NS + `FDH_CLK_NS - 1) / `FDH_CLK_NS)
`define FDH_WAIT_CYC 2
`endif

// ==== rtl/fdh_pkg.sv ====
// types for the fixed disk host attachment
package fdh_pkg;
    typedef enum logic [1:0] {
        FDH_RESET = 2'b00,
        FDH_INIT = 2'b01,
        FDH_IDLE = 2'b10,
        FDH_WAIT = 2'b11
    } fdh_state_e;
    typedef struct packed {
        logic sel_n;
        logic rd_n;
        logic wr_n;
        logic [3:0] register_select;
        logic [7:0] data;
    } fdh_bus_s;
endpackage

// ==== rtl/fdh_attach.sv ====
// fixed disk controller attachment to the 8-bit host bus
`timescale 1ns/100ps
`include "fdh_params.svh"
module fdh_attach
    import fdh_pkg::*;
(
    input wire logic mclk_i, // 250 mhz clock
    input wire logic resetn_i, // async reset, active low
    input wire logic drive_reset_in_i, // drive reset pin, high
    input wire logic disk_cs_n_i, // board decode select
    input wire logic io_read_strobe_n_i, // read strobe
    input wire logic io_write_strobe_n_i, // write strobe
    input wire logic [3:0] register_select_i, // register select
    input wire logic [7:0] host_data_bus_i, // bus level in
    output logic [7:0] host_data_bus_o, // bus drive value
    output logic host_data_bus_oe_o, // bus drive enable
    input wire logic dma_ack_ch_n_i, // dma acknowledge
    output logic dma_request_ch_o, // dma request
    output logic irq_o, // interrupt request
    output logic channel_ready_o, // high lets cycle end
    output logic disk_installed_n_o, // presence, low
    input wire logic data_avail_i, // core has dma data
    input wire logic status_done_i, // core returned status
    input wire logic [7:0] core_data_i, // core data byte
    output logic [7:0] cmd_byte_o, // last command byte
    output logic cmd_strobe_o // command byte written
);
    // synchroniser stages for the pin group
    fdh_bus_s s1_r; // first stage, may be metastable
    fdh_bus_s s2_r; // second stage, safe to decode
    // drive reset pin, two stages
    logic rst1_r; // first stage
    logic rst2_r; // second stage, high holds reset
    // dma acknowledge pin, two stages, low active
    logic ack1_n_r; // first stage
    logic ack2_n_r; // second stage
    // sequencer state and its shared counter
    fdh_state_e state_r; // reset, init, idle or wait
    logic [3:0] cnt_r; // init / wait counter
    // host visible state
    logic [7:0] ctrl_r; // attachment control
    logic irq_pend_r; // status returned, not yet read
    logic dreq_r; // dma request before enable gate
    logic [7:0] rdata_r; // read data, from flops
    // edge history
    logic acc_prev_r; // access seen last cycle
    logic ack_prev_n_r; // acknowledge seen last cycle
    logic stat_rd_prev_r; // status read seen last cycle
    // decoded access, all from the second stage
    logic acc; // selected read or write
    logic rd; // selected read
    logic wr; // selected write
    logic stat_rd; // selected read of status
    logic acc_rise; // first cycle of an access
    logic ack_fall; // first cycle of acknowledge
    logic stat_rd_end; // status read just finished
    // pins come from another domain; two flops each
    // resetting to idle pin levels avoids a false access
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_r <= '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
            s2_r <= '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
            rst1_r <= 1'b1;
            rst2_r <= 1'b1;
            ack1_n_r <= 1'b1;
            ack2_n_r <= 1'b1;
        end else begin
            s1_r <= '{disk_cs_n_i, io_read_strobe_n_i,
                io_write_strobe_n_i, register_select_i, host_data_bus_i};
            s2_r <= s1_r;
            rst1_r <= drive_reset_in_i;
            rst2_r <= rst1_r;
            ack1_n_r <= dma_ack_ch_n_i;
            ack2_n_r <= ack1_n_r;
        end
    end
    // decode from the second stage only; the first is never read
    assign rd = !s2_r.sel_n && !s2_r.rd_n;
    assign wr = !s2_r.sel_n && !s2_r.wr_n;
    assign acc = rd || wr;
    assign stat_rd = rd && (s2_r.register_select == `FDH_REG_STATUS);
    // one access per strobe; the strobe must drop between them
    assign acc_rise = acc && !acc_prev_r;
    assign ack_fall = !ack2_n_r && ack_prev_n_r;
    // clearing at the end lets the host see the pending bit
    assign stat_rd_end = stat_rd_prev_r && !stat_rd;
    // edge history for access, acknowledge and status reads
    // reset values match the idle pins, so no false edge
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_prev_r <= 1'b0;
            ack_prev_n_r <= 1'b1;
            stat_rd_prev_r <= 1'b0;
        end else begin
            acc_prev_r <= acc;
            ack_prev_n_r <= ack2_n_r;
            stat_rd_prev_r <= stat_rd;
        end
    end
    // sequencer: reset, init, idle, wait states
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= FDH_RESET;
            cnt_r <= 4'h0;
        end else if (rst2_r) begin
            state_r <= FDH_RESET;
            cnt_r <= 4'h0;
        end else begin
            case (state_r)
                // one cycle of reset state, then initialise
                FDH_RESET: begin
                    state_r <= FDH_INIT;
                    cnt_r <= 4'(`FDH_INIT_CYC);
                end
                // any access meanwhile sees ready low
                FDH_INIT: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= FDH_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                FDH_IDLE: begin
                    // each new access is stretched a little
                    if (acc_rise) begin
                        state_r <= FDH_WAIT;
                        cnt_r <= 4'(`FDH_WAIT_CYC);
                    end
                end
                // wait states until the counter runs out
                FDH_WAIT: begin
                    if (cnt_r == 4'h0) begin
                        state_r <= FDH_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                // unused code: recover through reset
                default: state_r <= FDH_RESET;
            endcase
        end
    end
    // ready low while stretching or not yet initialised
    // combinational, so the host sees it in the same cycle
    assign channel_ready_o = !(acc && (state_r != FDH_IDLE));
    // register writes, at the first cycle of a write
    // a long strobe therefore writes only once
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= `FDH_CTRL_RESET;
            cmd_byte_o <= 8'h00;
            cmd_strobe_o <= 1'b0;
        end else begin
            cmd_strobe_o <= 1'b0;
            // writes during drive reset are dropped
            if (rst2_r) begin
                ctrl_r <= `FDH_CTRL_RESET;
            end else if (wr && acc_rise) begin
                case (s2_r.register_select)
                    `FDH_REG_CTRL: ctrl_r <= s2_r.data;
                    `FDH_REG_CMD, `FDH_REG_DATA: begin
                        cmd_byte_o <= s2_r.data;
                        cmd_strobe_o <= 1'b1;
                    end
                    default: ; // other selects ignore writes
                endcase
            end
        end
    end
    // interrupt pending: set wins over status read clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_pend_r <= 1'b0;
        end else if (rst2_r) begin
            irq_pend_r <= 1'b0;
        end else if (status_done_i) begin
            irq_pend_r <= 1'b1;
        end else if (stat_rd_end) begin
            // cleared once the host has finished reading status
            irq_pend_r <= 1'b0;
        end
    end
    // the enable masks the line but keeps the pending bit
    assign irq_o = irq_pend_r && ctrl_r[`FDH_CTRL_IRQ_EN];
    // dma request holds until acknowledge falls
    // a new data event in the ack cycle wins over the clear
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dreq_r <= 1'b0;
        end else if (rst2_r) begin
            dreq_r <= 1'b0;
        end else if (data_avail_i && ctrl_r[`FDH_CTRL_DMA_EN]) begin
            dreq_r <= 1'b1;
        end else if (ack_fall) begin
            dreq_r <= 1'b0;
        end
    end
    assign dma_request_ch_o = dreq_r && ctrl_r[`FDH_CTRL_DMA_EN];
    // read data mux; status shows internal state
    // updates every cycle; the wait states cover the latency
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
        end else begin
            case (s2_r.register_select)
                `FDH_REG_DATA: rdata_r <= core_data_i;
                // status is assembled from live internal state
                `FDH_REG_STATUS: begin
                    rdata_r <= 8'h00;
                    rdata_r[`FDH_ST_BUSY] <= (state_r != FDH_IDLE);
                    rdata_r[`FDH_ST_IRQ] <= irq_pend_r;
                    rdata_r[`FDH_ST_DREQ] <= dreq_r;
                end
                `FDH_REG_CTRL: rdata_r <= ctrl_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end
    // read data leaves from flops, never from the mux
    assign host_data_bus_o = rdata_r;
    // drive only while selected and read strobe active
    assign host_data_bus_oe_o = rd;
    // presence is fixed: the attachment is always fitted
    assign disk_installed_n_o = 1'b0;
endmodule // fdh_attach

// ==== dv/fdh_attach_chk.sv ====
// port checker for the disk host attachment
`timescale 1ns/100ps
module fdh_attach_chk (
    input wire logic mclk_i, // clock
    input wire logic resetn_i, // reset, low
    input wire logic drive_reset_in_i, // drive reset
    input wire logic disk_cs_n_i, // select
    input wire logic io_read_strobe_n_i, // read
    input wire logic io_write_strobe_n_i, // write
    input wire logic [3:0] register_select_i, // reg select
    input wire logic [7:0] host_data_bus_i, // bus level
    input wire logic host_data_bus_oe_o, // bus drive
    input wire logic dma_ack_ch_n_i, // dma ack
    input wire logic dma_request_ch_o, // dma request
    input wire logic irq_o, // interrupt
    input wire logic channel_ready_o, // ready
    input wire logic disk_installed_n_o, // presence
    input wire logic [7:0] cmd_byte_o, // command byte
    input wire logic cmd_strobe_o // command pulse
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    AST_PRESENT: assert property (!disk_installed_n_o)
        else $error("presence not low");
    // only a selected read may drive the shared bus
    AST_OE_RD: assert property (host_data_bus_oe_o |->
        !$past(io_read_strobe_n_i, 2) && !$past(disk_cs_n_i, 2))
        else $error("bus driven outside read");
    // select 0 or 2 written, byte from the bus
    AST_CMD: assert property (cmd_strobe_o |->
        !$past(io_write_strobe_n_i, 2) &&
        ($past(register_select_i, 2) & 4'hd) == 4'h0 &&
        cmd_byte_o == $past(host_data_bus_i, 2))
        else $error("bad command capture");
    AST_ONE_PULSE: assert property (cmd_strobe_o |=> !cmd_strobe_o)
        else $error("command pulse too long");
    AST_RDY_MIN: assert property ($fell(channel_ready_o) |->
        !channel_ready_o [*3])
        else $error("wait too short");
    AST_RDY_MAX: assert property (!channel_ready_o &&
        !drive_reset_in_i |-> ##[1:20] channel_ready_o)
        else $error("wait never ends");
    AST_DRQ_ACK: assert property ($fell(dma_request_ch_o) |->
        !$past(dma_ack_ch_n_i, 2))
        else $error("request dropped before ack");
    AST_DRV_RST: assert property (drive_reset_in_i [*5] |->
        !irq_o && !dma_request_ch_o)
        else $error("outputs live in drive reset");
    cover property (cmd_strobe_o);
    cover property ($rose(irq_o));
    cover property ($fell(dma_request_ch_o));
endmodule // fdh_attach_chk
bind fdh_attach fdh_attach_chk fdh_attach_chk_inst (.*);

// ==== dv/fdh_dma_host.sv ====
// host dma side: acknowledges a pending request
`timescale 1ns/100ps
module fdh_dma_host (
    input wire logic mclk_i, // clock
    input wire logic dma_request_ch_i, // request in
    input wire logic [3:0] lag_i, // slowness, cycles
    output logic dma_ack_ch_n_o // acknowledge, low
);
    int n = 0; // cycles the request has waited
    initial dma_ack_ch_n_o = 1'b1;
    // never ack without a request, released with it
    always @(negedge mclk_i) begin
        n = dma_request_ch_i ? n + 1 : 0;
        dma_ack_ch_n_o <= !(dma_request_ch_i && n > lag_i);
    end
endmodule // fdh_dma_host

// ==== dv/fdh_attach_tb.sv ====
// self-checking bench for the disk host attachment
`timescale 1ns/100ps
module fdh_attach_tb;
    logic mclk_i = 0, resetn_i = 0, drive_reset_in_i = 0, disk_cs_n_i = 1;
    logic io_read_strobe_n_i = 1, io_write_strobe_n_i = 1;
    logic data_avail_i = 0, status_done_i = 0, host_data_bus_oe_o;
    logic dma_ack_ch_n_i, dma_request_ch_o, irq_o, channel_ready_o;
    logic disk_installed_n_o, cmd_strobe_o;
    logic [3:0] register_select_i = 0, lag = 0;
    logic [7:0] host_data_bus_i, host_data_bus_o, core_data_i = 0;
    logic [7:0] cmd_byte_o, hval = 0, rv, d, q[$];
    int seed = 76, err_total = 0, checked = 0;
    event rdone;
    always #2 mclk_i = ~mclk_i;
    // wire level: design drives, else host value
    assign host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : hval;
    fdh_attach fdh_attach_inst (.mclk_i, .resetn_i, .drive_reset_in_i,
        .disk_cs_n_i, .io_read_strobe_n_i, .io_write_strobe_n_i,
        .register_select_i, .host_data_bus_i, .host_data_bus_o,
        .host_data_bus_oe_o, .dma_ack_ch_n_i, .dma_request_ch_o, .irq_o,
        .channel_ready_o, .disk_installed_n_o, .data_avail_i,
        .status_done_i, .core_data_i, .cmd_byte_o, .cmd_strobe_o);
    fdh_dma_host fdh_dma_host_inst (.mclk_i, .dma_request_ch_i(
        dma_request_ch_o), .lag_i(lag), .dma_ack_ch_n_o(dma_ack_ch_n_i));
    task automatic chk(string s, logic [7:0] e, logic [7:0] g);
        checked++;
        if (e !== g) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // bounded wait at falling edges: ready, irq or request
    task automatic wt(int w, logic v);
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk_i);
            if ((w == 0 ? channel_ready_o : w == 1 ? irq_o :
                dma_request_ch_o) === v) return;
        end
        chk("wait", 8'(v), 8'hxx);
        complete_run();
    endtask
    // one host cycle, held until ready is seen high
    task automatic acc(logic w, logic [3:0] a, logic [7:0] x, m);
        @(negedge mclk_i);
        disk_cs_n_i = 0;
        register_select_i = a;
        hval = w ? x : ~x;
        if (w) io_write_strobe_n_i = 0;
        else io_read_strobe_n_i = 0;
        wt(0, 0);
        wt(0, 1);
        chk("oe", 8'(!w), 8'(host_data_bus_oe_o));
        rv = host_data_bus_o & m;
        if (!w) ->rdone;
        @(negedge mclk_i);
        {disk_cs_n_i, io_read_strobe_n_i, io_write_strobe_n_i} = 3'b111;
        hval = ~hval; // released bus stops showing old byte
    endtask
    task automatic pl(bit s);
        @(negedge mclk_i);
        if (s) status_done_i = 1;
        else data_avail_i = 1;
        @(negedge mclk_i);
        {status_done_i, data_avail_i} = 2'b00;
    endtask
    // oldest note against each result as it shows
    always @(negedge mclk_i) begin
        if (cmd_strobe_o) chk("cmd", q.pop_front(), cmd_byte_o);
    end
    always @(rdone) chk("read", q.pop_front(), rv);
    initial begin
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i) resetn_i = 1;
        repeat (16) @(negedge mclk_i);
        chk("present", 8'h00, 8'(disk_installed_n_o));
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            q.push_back(d);
            acc(1, i[0] ? 4'h0 : 4'h2, d, 8'hff);
        end
        acc(1, 4'h1, 8'h5a, 8'hff);
        acc(1, 4'h3, 8'h03, 8'hff);
        core_data_i = 8'($random(seed));
        q.push_back(core_data_i);
        acc(0, 4'h0, core_data_i, 8'hff);
        q.push_back(8'h00);
        acc(0, 4'h5, 8'h00, 8'hff);
        pl(1);
        wt(1, 1);
        q.push_back(8'h02);
        acc(0, 4'h1, 8'h02, 8'h02);
        wt(1, 0);
        q.push_back(8'h00);
        acc(0, 4'h1, 8'h00, 8'h02);
        for (int i = 0; i < 2; i++) begin
            lag = i[0] ? 4'h7 : 4'(($random(seed)) & 3);
            pl(0);
            wt(2, 1);
            wt(2, 0);
        end
        acc(1, 4'h3, 8'h00, 8'hff);
        pl(1);
        pl(0);
        repeat (10) @(negedge mclk_i);
        chk("masked", 8'h00, {6'h00, irq_o, dma_request_ch_o});
        acc(1, 4'h3, 8'h01, 8'hff);
        wt(1, 1);
        drive_reset_in_i = 1;
        repeat (8) @(negedge mclk_i);
        chk("reset", 8'h00, 8'(irq_o));
        drive_reset_in_i = 0;
        q.push_back(8'ha5);
        acc(1, 4'h2, 8'ha5, 8'hff);
        repeat (4) @(negedge mclk_i);
        complete_run();
    end
endmodule // fdh_attach_tb
